// *** rtl/flow_pulse_params.svh ***
// Widths, rate limits, reset values and timing counts of the flow pulse emitter
`ifndef FLOW_PULSE_PARAMS_SVH
`define FLOW_PULSE_PARAMS_SVH

// Clock and base time unit
`define CLK_PERIOD_NS 10
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)

// Schedule, in milliseconds
`define SECOND_MS 1000
`define STRAP_SAMPLE_MS 1000
`define SETTLE_MS 16000
`define MEAS_NORMAL_MS 500
`define MEAS_TEST_DIV 4

// Burst shape, in milliseconds
`define PULSE_HIGH_MS 3
`define PULSE_MIN_MS 2
`define PULSE_MAX_MS 5
`define BURST_PAUSE_MS 30
`define BURST_LEN 16
`define GAP_SLOW_MS 20
`define GAP_MID_MS 8
`define GAP_FAST_MS 3
`define GAP_SLOW_MAX 25
`define GAP_MID_MAX 60

// Rate limits; flow is in 1/256 pulse per second
`define SAT_PULSES 125
`define CUTOFF_Q8 24'h00_0040
`define AVG_SHIFT 3

// Readout and reset values
`define VOL_WIDTH 40
`define AVG_RESET 24'h00_0000

`endif

// *** rtl/flow_pulse_pkg.sv ***
// Types shared by the flow pulse emitter files
package flow_pulse_pkg;

    // Power-up strap decision, Gray along boot, arm, test
    typedef enum logic [1:0]
    {
        T_BOOT = 2'b00,
        T_ARM = 2'b01,
        T_TEST = 2'b11,
        T_NORMAL = 2'b10
    } test_mode_e;

    // Pulse burst sequencer
    typedef enum logic [1:0]
    {
        B_IDLE = 2'b00,
        B_HIGH = 2'b01,
        B_LOW = 2'b11,
        B_PAUSE = 2'b10
    } burst_e;

    // Gated volume accumulation
    typedef enum logic [1:0]
    {
        G_IDLE = 2'b00,
        G_FIRST = 2'b01,
        G_RUN = 2'b11,
        G_DONE = 2'b10
    } gate_e;

endpackage

// *** rtl/flow_volume_gate.sv ***
// Gated volume accumulator with start and stop interpolation
`timescale 1ns/1ps
`include "flow_pulse_params.svh"

module flow_volume_gate
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Timing
    input wire logic secTick,
    input wire logic [9:0] msPhase,
    // Gate and interval volume
    input wire logic gateLevel,
    input wire logic [15:0] intervalVol,
    // Result
    output logic [`VOL_WIDTH-1:0] accVol,
    output logic volumeReady
);

    flow_pulse_pkg::gate_e gate_reg;
    flow_pulse_pkg::gate_e gate_next;
    logic [9:0] startPhase_reg;
    logic [`VOL_WIDTH-1:0] acc_reg;
    logic [`VOL_WIDTH-1:0] acc_next;
    logic gatePrev_reg;
    logic [9:0] weight;
    logic [`VOL_WIDTH-1:0] part;

    wire gateRise = gateLevel && !gatePrev_reg;
    wire gateFall = !gateLevel && gatePrev_reg;

    assign part = `VOL_WIDTH'(intervalVol) * `VOL_WIDTH'(weight);
    assign accVol = acc_reg;
    assign volumeReady = (gate_reg == flow_pulse_pkg::G_DONE);

    // ----------------------------------------
    // Interpolation weights, in milliseconds
    // ----------------------------------------
    always_comb
    begin
        gate_next = gate_reg;
        acc_next = acc_reg;
        weight = 10'h000;
        unique case (gate_reg)
            flow_pulse_pkg::G_IDLE, flow_pulse_pkg::G_DONE:
            begin
                if (gateRise)
                begin
                    gate_next = flow_pulse_pkg::G_FIRST;
                    acc_next = '0;
                end
            end
            flow_pulse_pkg::G_FIRST:
            begin
                if (gateFall)
                begin
                    weight = msPhase - startPhase_reg;
                    acc_next = acc_reg + part;
                    gate_next = flow_pulse_pkg::G_DONE;
                end
                else if (secTick)
                begin
                    weight = 10'(`SECOND_MS) - startPhase_reg;
                    acc_next = acc_reg + part;
                    gate_next = flow_pulse_pkg::G_RUN;
                end
            end
            flow_pulse_pkg::G_RUN:
            begin
                if (gateFall)
                begin
                    weight = msPhase;
                    acc_next = acc_reg + part;
                    gate_next = flow_pulse_pkg::G_DONE;
                end
                else if (secTick)
                begin
                    weight = 10'(`SECOND_MS);
                    acc_next = acc_reg + part;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            gate_reg <= flow_pulse_pkg::G_IDLE;
            acc_reg <= '0;
            startPhase_reg <= 10'h000;
            gatePrev_reg <= 1'b0;
        end
        else
        begin
            gate_reg <= gate_next;
            acc_reg <= acc_next;
            gatePrev_reg <= gateLevel;
            if (gateRise)
                startPhase_reg <= msPhase;
        end
    end

    a_ready_after_stop: assert property (@(posedge clk_sys) disable iff (srst)
        (gateFall && gate_reg != flow_pulse_pkg::G_IDLE) |=> volumeReady && $fell(gatePrev_reg))
        else $error("volume not ready after gate stop");

    a_run_full_weight: assert property (@(posedge clk_sys) disable iff (srst)
        (gate_reg == flow_pulse_pkg::G_RUN && secTick && !gateFall)
        |=> acc_reg == $past(acc_reg) + $past(intervalVol) * `SECOND_MS)
        else $error("intermediate interval not added whole");

endmodule

// *** rtl/flow_pulse_emitter.sv ***
// Flow pulse emitter with strap test mode, gated accumulation and serial readout
`timescale 1ns/1ps
`include "flow_pulse_params.svh"

// Overview of operation
// - No pulses while averaged flow is below cutoff or reversed.
// - Above saturation flow pulses continue at the maximum rate.
// - Maximum rate is 125 pulses per second whatever the meter factor.
// - Bursts of up to 16 pulses are launched within each one-second interval.
// - Pulse count for the next interval is recomputed every second.
// - Each pulse is high 2 to 5 ms; gap follows the rate.
// - Bursts are separated by a pause of about 30 ms.
// - Pulse count comes from an average over several measurements.
// - After flow stops a decaying tail lasts while the average, shrinking by 1/8 per measurement, stays above cutoff.
// - Test mode runs measurements four times as often.
// - Strap grounded at power-up enters test mode after about 1 s.
// - Only power removal leaves test mode.
// - Volume is accumulated while the gated test runs.
// - Accumulation uses the same interval volume as the pulse count.
// - First and last intervals are weighted by their share inside the gate.
// - Accumulated volume is readable serially after the test.
// - Pulse emission stops for the rest of the second when the strap is released at test end.
// - Between cutoff and saturation pulse count is proportional to flow.
// - Output may need up to 16 s after power-up to be correct.
module flow_pulse_emitter
#(
    parameter int unsigned CYCLES_PER_MS = `MS_CYCLES
)
(
    // Clock and power-up reset
    input wire logic clk_sys,
    input wire logic srst,
    // Measurement engine
    output logic measStart,
    input wire logic flowValid,
    input wire logic signed [23:0] flowSample,
    // Verification strap pin, low when grounded
    input wire logic strapN,
    // Serial readout pins
    input wire logic readSelN,
    input wire logic readClk,
    output logic readData,
    // Pulse output and status
    output logic pulseOut,
    output logic testMode,
    output logic gateActive,
    output logic volumeReady
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic strapMeta_reg, strapSync_reg;
    logic selMeta_reg, selSync_reg, selPrev_reg;
    logic rclkMeta_reg, rclkSync_reg, rclkPrev_reg;
    logic [16:0] msDiv_reg;
    logic [9:0] msPhase_reg;
    logic [13:0] upMs_reg;
    logic [9:0] measMs_reg;
    logic measStart_reg;
    flow_pulse_pkg::test_mode_e mode_reg;
    flow_pulse_pkg::test_mode_e mode_next;
    logic signed [23:0] avg_reg;
    logic [7:0] carry_reg;
    logic [15:0] curVol_reg;
    logic [6:0] pending_reg;
    logic [6:0] pending_next;
    logic [6:0] rate_reg;
    flow_pulse_pkg::burst_e burst_reg;
    flow_pulse_pkg::burst_e burst_next;
    logic [4:0] burstMs_reg;
    logic [4:0] burstMs_next;
    logic [3:0] inBurst_reg;
    logic [3:0] inBurst_next;
    logic pulseOut_reg;
    logic gatePrev_reg;
    logic [`VOL_WIDTH-1:0] shift_reg;
    logic [`VOL_WIDTH-1:0] accVol;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [4:0] gapFor(input logic [6:0] rate);
        if (rate <= 7'(`GAP_SLOW_MAX))
            return 5'(`GAP_SLOW_MS);
        else if (rate <= 7'(`GAP_MID_MAX))
            return 5'(`GAP_MID_MS);
        else
            return 5'(`GAP_FAST_MS);
    endfunction

    function automatic logic msDone(input logic [4:0] count, input logic [4:0] limit);
        return count == limit - 5'd1;
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk_sys)
    begin
        strapMeta_reg <= strapN;
        strapSync_reg <= strapMeta_reg;
        selMeta_reg <= readSelN;
        selSync_reg <= selMeta_reg;
        selPrev_reg <= selSync_reg;
        rclkMeta_reg <= readClk;
        rclkSync_reg <= rclkMeta_reg;
        rclkPrev_reg <= rclkSync_reg;
    end

    wire strapLow = !strapSync_reg;
    wire selFall = selPrev_reg && !selSync_reg;
    wire rclkRise = rclkSync_reg && !rclkPrev_reg;

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    wire msTick = (msDiv_reg == 17'(CYCLES_PER_MS - 1));
    wire secTick = msTick && (msPhase_reg == 10'(`SECOND_MS - 1));
    wire settled = (upMs_reg == 14'(`SETTLE_MS));
    wire strapDecide = msTick && (upMs_reg == 14'(`STRAP_SAMPLE_MS - 1));
    wire [9:0] measLimit = testMode ? 10'(`MEAS_NORMAL_MS / `MEAS_TEST_DIV - 1) : 10'(`MEAS_NORMAL_MS - 1);
    wire measDue = msTick && (measMs_reg == measLimit);

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            msDiv_reg <= 17'h0_0000;
            msPhase_reg <= 10'h000;
            upMs_reg <= 14'h0000;
            measMs_reg <= 10'h000;
            measStart_reg <= 1'b0;
        end
        else
        begin
            msDiv_reg <= msTick ? 17'h0_0000 : msDiv_reg + 17'h0_0001;
            measStart_reg <= measDue;
            if (msTick)
            begin
                msPhase_reg <= secTick ? 10'h000 : msPhase_reg + 10'h001;
                // Restart when test mode shortens the period
                measMs_reg <= (measDue || measMs_reg > measLimit) ? 10'h000 : measMs_reg + 10'h001;
                if (!settled)
                    upMs_reg <= upMs_reg + 14'h0001;
            end
        end
    end

    // ----------------------------------------
    // Test mode entry by strap
    // ----------------------------------------
    always_comb
    begin
        mode_next = mode_reg;
        unique case (mode_reg)
            flow_pulse_pkg::T_BOOT:
            begin
                // strap sampled 1 s after power-up
                if (strapDecide)
                    mode_next = strapLow ? flow_pulse_pkg::T_ARM : flow_pulse_pkg::T_NORMAL;
            end
            flow_pulse_pkg::T_ARM:
            begin
                if (!strapLow)
                    mode_next = flow_pulse_pkg::T_TEST;
            end
            flow_pulse_pkg::T_TEST:
                mode_next = flow_pulse_pkg::T_TEST;
            flow_pulse_pkg::T_NORMAL:
                mode_next = flow_pulse_pkg::T_NORMAL;
        endcase
    end

    wire gateLevel = (mode_reg == flow_pulse_pkg::T_TEST) && strapLow;
    wire gateFall = gatePrev_reg && !gateLevel;

    // ----------------------------------------
    // Averaging and per-second count
    // ----------------------------------------
    wire signed [24:0] avgDiff = 25'(flowSample) - 25'(avg_reg);
    wire signed [24:0] avgStep = avgDiff >>> `AVG_SHIFT;
    wire belowCut = avg_reg < $signed(`CUTOFF_Q8);
    wire [15:0] intervalVol = belowCut ? 16'h0000 : (|avg_reg[23:16]) ? 16'hFFFF : avg_reg[15:0];
    wire [16:0] total = {1'b0, intervalVol} + {9'h000, carry_reg};
    wire [8:0] whole = total[16:8];
    wire saturated = whole >= 9'(`SAT_PULSES);
    wire [6:0] countNext = saturated ? 7'(`SAT_PULSES) : whole[6:0];

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            mode_reg <= flow_pulse_pkg::T_BOOT;
            avg_reg <= `AVG_RESET;
            carry_reg <= 8'h00;
            curVol_reg <= 16'h0000;
            rate_reg <= 7'h00;
            gatePrev_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            gatePrev_reg <= gateLevel;
            if (flowValid)
                avg_reg <= avg_reg + avgStep[23:0];
            if (secTick)
            begin
                carry_reg <= (saturated || belowCut) ? 8'h00 : total[7:0];
                curVol_reg <= intervalVol;
                rate_reg <= countNext;
            end
        end
    end

    // ----------------------------------------
    // Burst sequencer
    // ----------------------------------------
    wire step = msTick && !secTick;

    always_comb
    begin
        burst_next = burst_reg;
        burstMs_next = burstMs_reg;
        inBurst_next = inBurst_reg;
        pending_next = pending_reg;
        if (step)
            burstMs_next = burstMs_reg + 5'd1;
        unique case (burst_reg)
            flow_pulse_pkg::B_IDLE:
            begin
                if (step && pending_reg != 7'h00)
                begin
                    burst_next = flow_pulse_pkg::B_HIGH;
                    burstMs_next = 5'd0;
                    inBurst_next = 4'h0;
                    pending_next = pending_reg - 7'h01;
                end
            end
            flow_pulse_pkg::B_HIGH:
            begin
                if (step && msDone(burstMs_reg, 5'(`PULSE_HIGH_MS)))
                begin
                    burstMs_next = 5'd0;
                    if (pending_reg == 7'h00)
                        burst_next = flow_pulse_pkg::B_IDLE;
                    else if (inBurst_reg == 4'(`BURST_LEN - 1))
                        burst_next = flow_pulse_pkg::B_PAUSE;
                    else
                        burst_next = flow_pulse_pkg::B_LOW;
                end
            end
            flow_pulse_pkg::B_LOW:
            begin
                if (step && msDone(burstMs_reg, gapFor(rate_reg)))
                begin
                    burst_next = flow_pulse_pkg::B_HIGH;
                    burstMs_next = 5'd0;
                    inBurst_next = inBurst_reg + 4'h1;
                    pending_next = pending_reg - 7'h01;
                end
            end
            flow_pulse_pkg::B_PAUSE:
            begin
                if (step && msDone(burstMs_reg, 5'(`BURST_PAUSE_MS)))
                begin
                    burst_next = flow_pulse_pkg::B_HIGH;
                    burstMs_next = 5'd0;
                    inBurst_next = 4'h0;
                    pending_next = pending_reg - 7'h01;
                end
            end
        endcase
        if (secTick)
            pending_next = settled ? countNext : 7'h00;
        if (gateFall)
        begin
            pending_next = 7'h00;
            burst_next = flow_pulse_pkg::B_IDLE;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            burst_reg <= flow_pulse_pkg::B_IDLE;
            burstMs_reg <= 5'd0;
            inBurst_reg <= 4'h0;
            pending_reg <= 7'h00;
            pulseOut_reg <= 1'b0;
        end
        else
        begin
            burst_reg <= burst_next;
            burstMs_reg <= burstMs_next;
            inBurst_reg <= inBurst_next;
            pending_reg <= pending_next;
            pulseOut_reg <= (burst_next == flow_pulse_pkg::B_HIGH);
        end
    end

    // ----------------------------------------
    // Gated accumulation and serial readout
    // ----------------------------------------
    // same interval volume
    flow_volume_gate u_gate
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .secTick(secTick),
        .msPhase(msPhase_reg),
        .gateLevel(gateLevel),
        .intervalVol(curVol_reg),
        .accVol(accVol),
        .volumeReady(volumeReady)
    );

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            shift_reg <= '0;
        else if (!gateLevel && selFall)
            shift_reg <= accVol;
        else if (!gateLevel && !selSync_reg && rclkRise)
            shift_reg <= {shift_reg[`VOL_WIDTH-2:0], 1'b0};
    end

    assign measStart = measStart_reg;
    assign pulseOut = pulseOut_reg;
    assign readData = shift_reg[`VOL_WIDTH-1];
    assign testMode = (mode_reg == flow_pulse_pkg::T_ARM) || (mode_reg == flow_pulse_pkg::T_TEST);
    assign gateActive = gateLevel;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    int hiCycles;
    always_ff @(posedge clk_sys)
    begin
        if (srst || !pulseOut_reg)
            hiCycles <= 0;
        else
            hiCycles <= hiCycles + 1;
    end

    a_cutoff_no_pulse: assert property (@(posedge clk_sys) disable iff (srst)
        (secTick && belowCut && !gateFall) |=> pending_reg == 7'h00 ##1 !pulseOut_reg)
        else $error("pulses scheduled below cutoff");

    a_rate_ceiling: assert property (@(posedge clk_sys) disable iff (srst)
        (secTick && settled && saturated && !gateFall) |=> pending_reg == 7'(`SAT_PULSES))
        else $error("saturated count not held at maximum");

    a_pulse_width: assert property (@(posedge clk_sys) disable iff (srst)
        $fell(pulseOut_reg) && !$past(gateFall)
        |-> $past(hiCycles) >= int'(`PULSE_MIN_MS * CYCLES_PER_MS) - 1
        && $past(hiCycles) < int'(`PULSE_MAX_MS * CYCLES_PER_MS))
        else $error("pulse width outside limits");

    a_burst_pause: assert property (@(posedge clk_sys) disable iff (srst)
        (burst_reg == flow_pulse_pkg::B_PAUSE && step && burstMs_reg == 5'(`BURST_PAUSE_MS - 1) && !gateFall)
        |=> burst_reg == flow_pulse_pkg::B_HIGH ##1 pulseOut_reg)
        else $error("burst pause did not end at its length");

    a_meas_period: assert property (@(posedge clk_sys) disable iff (srst)
        measStart_reg |-> $past(msTick) && $past(measMs_reg) == $past(measLimit) ##1 !measStart_reg)
        else $error("measurement start off schedule");

    a_test_entry: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(testMode) |-> $past(strapDecide) && $past(strapLow))
        else $error("test mode entered without strap at decision time");

    a_test_sticky: assert property (@(posedge clk_sys) disable iff (srst)
        testMode |=> testMode)
        else $error("test mode left without power-down");

    a_gate_stop: assert property (@(posedge clk_sys) disable iff (srst)
        gateFall |=> !pulseOut_reg && pending_reg == 7'h00)
        else $error("pulses continued after gate release");

    a_settle_quiet: assert property (@(posedge clk_sys) disable iff (srst)
        !settled |-> !pulseOut_reg)
        else $error("pulse before settling time");

endmodule

// *** testbench/flow_meas_model.sv ***
// Measurement engine model answering sample requests
`timescale 1ns/1ps
module flow_meas_model
(
    // Clock
    input wire logic clk_sys,
    // Request and answer
    input wire logic measStart,
    output logic flowValid,
    output logic signed [23:0] flowSample,
    // Flow level and answer delay from the bench
    input wire logic signed [23:0] flowLevel,
    input wire logic [3:0] answerDelay
);
    logic [4:0] waitCnt = 5'h00;
    logic signed [23:0] lastSample = 24'h00_0000;
    initial flowValid = 1'b0;
    initial flowSample = 24'h00_0000;
    // Sample lines show the inverse of the last value when idle
    always @(posedge clk_sys)
    begin
        flowValid <= waitCnt == 5'h01;
        flowSample <= (waitCnt == 5'h01) ? flowLevel : ~lastSample;
        if (waitCnt == 5'h01)
            lastSample <= flowLevel;
        if (measStart)
            waitCnt <= {1'b0, answerDelay} + 5'h01;
        else if (waitCnt != 5'h00)
            waitCnt <= waitCnt - 5'h01;
    end
endmodule

// *** testbench/flow_pulse_emitter_tb.sv ***
// Self-checking bench for the flow pulse emitter
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
    begin comparisons++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value %s expected %0d seen %0d", what, exp, got); end end
module flow_pulse_emitter_tb;
    localparam int unsigned CPM = 2;
    localparam int SEC = 1000 * CPM;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic strapN = 1'b1;
    logic readSelN = 1'b1;
    logic readClk = 1'b0;
    logic measStart, flowValid, readData, pulseOut, testMode, gateActive, volumeReady;
    logic signed [23:0] flowSample;
    logic signed [23:0] flowLevel = 24'h10_0000;
    logic [3:0] answerDelay = 4'h0;
    logic pulsePrev = 1'b0;
    logic [39:0] vol;
    int fails = 0, comparisons = 0, rises = 0, hiLen = 0, minHi = 99, maxHi = 0, n;
    always #5 clk_sys = ~clk_sys;
    flow_pulse_emitter #(.CYCLES_PER_MS(CPM)) i_flow_pulse_emitter (.clk_sys(clk_sys), .srst(srst),
        .measStart(measStart), .flowValid(flowValid), .flowSample(flowSample), .strapN(strapN),
        .readSelN(readSelN), .readClk(readClk), .readData(readData), .pulseOut(pulseOut),
        .testMode(testMode), .gateActive(gateActive), .volumeReady(volumeReady));
    flow_meas_model i_flow_meas_model (.clk_sys(clk_sys), .measStart(measStart), .flowValid(flowValid),
        .flowSample(flowSample), .flowLevel(flowLevel), .answerDelay(answerDelay));
    // Pulse edge count and high width
    always @(posedge clk_sys)
    begin
        pulsePrev <= pulseOut;
        hiLen <= (pulseOut === 1'b1) ? hiLen + 1 : 0;
        if (pulseOut === 1'b1 && pulsePrev === 1'b0)
            rises <= rises + 1;
        if (pulseOut === 1'b0 && pulsePrev === 1'b1)
        begin
            minHi <= (hiLen < minHi) ? hiLen : minHi;
            maxHi <= (hiLen > maxHi) ? hiLen : maxHi;
        end
    end
    task automatic do_reset(input logic strapLevel);
        @(posedge clk_sys) srst <= 1'b1;
        strapN <= strapLevel;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
    endtask
    task automatic meas_period(output int p);
        int k;
        k = 0;
        p = 0;
        while (measStart !== 1'b1 && k < 3000) begin @(posedge clk_sys); k++; end
        @(posedge clk_sys);
        while (measStart !== 1'b1 && p < 3000) begin @(posedge clk_sys); p++; end
        p++;
    endtask
    task automatic count_pulses(input int secs, output int c);
        int s;
        s = rises;
        repeat (secs * SEC) @(posedge clk_sys);
        c = rises - s;
    endtask
    task automatic read_volume(output logic [39:0] v);
        @(posedge clk_sys) readSelN <= 1'b0;
        repeat (6) @(posedge clk_sys);
        for (int i = 39; i >= 0; i--)
        begin
            v[i] = readData;
            readClk <= 1'b1;
            repeat (5) @(posedge clk_sys);
            readClk <= 1'b0;
            repeat (5) @(posedge clk_sys);
        end
        readSelN <= 1'b1;
    endtask
    task automatic test_mode_gate();
        do_reset(1'b0);
        repeat (SEC - 20) @(posedge clk_sys);
        `CHECK("testMode early", 1'b0, testMode)
        repeat (40) @(posedge clk_sys);
        `CHECK("testMode", 1'b1, testMode)
        strapN <= 1'b1;
        meas_period(n);
        `CHECK("test period", SEC / 8, n)
        strapN <= 1'b0;
        repeat (5) @(posedge clk_sys);
        `CHECK("gateActive", 1'b1, gateActive)
        repeat (2500 * CPM - 5) @(posedge clk_sys);
        strapN <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHECK("gate end", 1'b0, gateActive)
        `CHECK("volumeReady", 1'b1, volumeReady)
        `CHECK("testMode kept", 1'b1, testMode)
        repeat (2 * SEC) @(posedge clk_sys);
        read_volume(vol);
        `CHECK("accVol", 40'd65535 * 40'd2500, vol)
    endtask
    task automatic normal_pulses();
        do_reset(1'b1);
        flowLevel <= 24'h00_0A07;
        answerDelay <= 4'h5;
        repeat (SEC + 100) @(posedge clk_sys);
        `CHECK("testMode normal", 1'b0, testMode)
        meas_period(n);
        `CHECK("normal period", SEC / 2, n)
        count_pulses(13, n);
        `CHECK("settle pulses", 0, n)
        repeat (8 * SEC) @(posedge clk_sys);
        count_pulses(4, n);
        `CHECK("mid rate", 1'b1, n >= 39 && n <= 41)
        flowLevel <= 24'h10_0000;
        repeat (2 * SEC) @(posedge clk_sys);
        count_pulses(1, n);
        `CHECK("saturated", 125, n)
        `CHECK("pulse width", 1'b1, minHi >= 2 * CPM && maxHi <= 5 * CPM)
        flowLevel <= 24'hF0_0000;
        repeat (3 * SEC) @(posedge clk_sys);
        count_pulses(1, n);
        `CHECK("reverse", 0, n)
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        test_mode_gate();
        normal_pulses();
        report_and_stop();
    end
    // Watchdog above the expected run of about 80000 cycles
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end
endmodule
